// >>> sbw_pkg.sv
// constants, field layout and types of the staged boot/runtime watchdog
// assumes a 10 MHz aclk; all timeouts are counted in 1 ms ticks
package sbw_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TW = 21;
   // timeouts in milliseconds
   localparam logic [20:0] T_1S = 21'h003E8;
   localparam logic [20:0] T_2S = 21'h007D0;
   localparam logic [20:0] T_5S = 21'h01388;
   localparam logic [20:0] T_10S = 21'h02710;
   localparam logic [20:0] T_30S = 21'h07530;
   localparam logic [20:0] T_1M = 21'h0EA60;
   localparam logic [20:0] T_2M = 21'h1D4C0;
   localparam logic [20:0] T_5M = 21'h493E0;
   localparam logic [20:0] T_10M = 21'h927C0;
   localparam logic [20:0] T_30M = 21'h1B7740;
   // ==========================================================
   // register map
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_TRIG = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_INT_STAT = 5'h0C;
   localparam logic [4:0] OFS_INT_MASK = 5'h10;
   localparam logic [31:0] CFG_RESET = 32'h00000408;
   localparam logic [4:0] MASK_RESET = 5'h00;
   // configuration fields: position of lowest bit
   localparam int F_POST = 0;
   localparam int F_PAUSE = 3;
   localparam int F_MODE = 4;
   localparam int F_DELAY = 6;
   localparam int F_EV1 = 9;
   localparam int F_EV2 = 11;
   localparam int F_EV3 = 13;
   localparam int F_TO1 = 15;
   localparam int F_TO2 = 19;
   localparam int F_TO3 = 23;
   localparam int F_RESTART = 27;
   // interrupt status bits
   localparam int I_BOOT = 0;
   localparam int I_ARM = 4;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      RT_IDLE = 2'b00,
      RT_DELAY = 2'b01,
      RT_STAGE = 2'b10,
      RT_DONE = 2'b11
   } sbw_rt_state_e;
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ONCE = 2'b01,
      MODE_SINGLE = 2'b10,
      MODE_REPEAT = 2'b11
   } sbw_mode_e;
   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_PM = 2'b01,
      ACT_RESET = 2'b10,
      ACT_PWR = 2'b11
   } sbw_act_e;
endpackage

// >>> sbw_tmr_if.sv
// control bundle between the watchdog core and one countdown timer
// assumes both ends run on the same aclk
interface sbw_tmr_if;
   logic load;
   logic run;
   logic [20:0] limit;
   logic expired;
   modport ctl (output load, output run, output limit, input expired);
   modport tmr (input load, input run, input limit, output expired);
endinterface

// >>> sbw_tick.sv
// millisecond tick prescaler
// assumes aclk at the rate given by CLK_PERIOD_NS
module sbw_tick #(
   parameter int unsigned CYC = sbw_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // one-cycle pulse every CYC cycles
   output logic tick
);
   logic [31:0] cnt;

   // ==========================================================
   // free running divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 32'h00000000;
         tick <= 1'b0;
      end else if (cnt == 32'(CYC - 1)) begin
         cnt <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule

// >>> sbw_timer.sv
// loadable countdown timer in tick units
// assumes tick is a one-cycle pulse on aclk
module sbw_timer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // time base
   input wire logic tick,
   // control from the core
   sbw_tmr_if.tmr t
);
   logic [20:0] cnt;

   // ==========================================================
   // load wins over counting; expiry pulses once per load
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 21'h000000;
         t.expired <= 1'b0;
      end else if (t.load) begin
         cnt <= t.limit;
         t.expired <= 1'b0;
      end else if (t.run && tick && cnt != 21'h000000) begin
         cnt <= cnt - 21'h000001;
         t.expired <= (cnt == 21'h000001);
      end else begin
         t.expired <= 1'b0;
      end
   end
endmodule

// >>> sbw_wdt.sv
// staged boot and runtime watchdog with an AXI4-Lite register slave
// assumes pins are asynchronous to aclk and synchronises them here
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
module sbw_wdt #(
   parameter int unsigned TICK_CYC = sbw_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // platform pins
   input wire logic post_active,
   input wire logic ui_wait,
   input wire logic os_boot,
   // actions
   output logic sys_reset,
   output logic pwrbtn_evt,
   output logic pm_overtemp,
   output logic pm_fatal,
   output logic irq
);
   sbw_tmr_if boot_if();
   sbw_tmr_if rt_if();
   logic tick;
   logic [2:0] sync1, sync2;
   logic boot_d;
   logic [31:0] cfg;
   logic [4:0] int_mask, int_stat, int_set;
   logic aw_got, w_got;
   logic [4:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic kick;
   sbw_pkg::sbw_rt_state_e state;
   logic [1:0] stage;
   logic rt_load;
   logic [20:0] rt_limit;
   logic fire;
   logic [1:0] fire_act;
   logic post_s, ui_s, arm_edge;
   logic [1:0] mode, ev_next;
   logic last;

   // ==========================================================
   // lookup functions
   function automatic logic [2:0] dec(input logic [4:0] a);
      if (a == sbw_pkg::OFS_CFG) dec = 3'h1;
      else if (a == sbw_pkg::OFS_TRIG) dec = 3'h2;
      else if (a == sbw_pkg::OFS_STATUS) dec = 3'h3;
      else if (a == sbw_pkg::OFS_INT_STAT) dec = 3'h4;
      else if (a == sbw_pkg::OFS_INT_MASK) dec = 3'h5;
      else dec = 3'h0;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) merge[i*8 +: 8] = n[i*8 +: 8];
      end
   endfunction

   function automatic logic [20:0] boot_ms(input logic [2:0] s);
      case (s)
         3'h1: boot_ms = sbw_pkg::T_30S;
         3'h2: boot_ms = sbw_pkg::T_1M;
         3'h3: boot_ms = sbw_pkg::T_2M;
         3'h4: boot_ms = sbw_pkg::T_5M;
         3'h5: boot_ms = sbw_pkg::T_10M;
         default: boot_ms = sbw_pkg::T_30M;
      endcase
   endfunction

   function automatic logic [20:0] delay_ms(input logic [2:0] s);
      case (s)
         3'h1: delay_ms = sbw_pkg::T_10S;
         3'h2: delay_ms = sbw_pkg::T_30S;
         3'h3: delay_ms = sbw_pkg::T_1M;
         3'h4: delay_ms = sbw_pkg::T_2M;
         3'h5: delay_ms = sbw_pkg::T_5M;
         3'h6: delay_ms = sbw_pkg::T_10M;
         default: delay_ms = sbw_pkg::T_30M;
      endcase
   endfunction

   function automatic logic [20:0] stage_ms(input logic [3:0] s);
      case (s)
         4'h0: stage_ms = sbw_pkg::T_1S;
         4'h1: stage_ms = sbw_pkg::T_2S;
         4'h2: stage_ms = sbw_pkg::T_5S;
         4'h3: stage_ms = sbw_pkg::T_10S;
         4'h4: stage_ms = sbw_pkg::T_30S;
         4'h5: stage_ms = sbw_pkg::T_1M;
         4'h6: stage_ms = sbw_pkg::T_2M;
         4'h7: stage_ms = sbw_pkg::T_5M;
         4'h8: stage_ms = sbw_pkg::T_10M;
         default: stage_ms = sbw_pkg::T_30M;
      endcase
   endfunction

   // action of stage n; stage one has no disabled choice
   function automatic logic [1:0] ev_of(input logic [31:0] c, input logic [1:0] n);
      case (n)
         2'h1: ev_of = (c[sbw_pkg::F_EV1 +: 2] == 2'h0) ? sbw_pkg::ACT_RESET : c[sbw_pkg::F_EV1 +: 2];
         2'h2: ev_of = c[sbw_pkg::F_EV2 +: 2];
         default: ev_of = c[sbw_pkg::F_EV3 +: 2];
      endcase
   endfunction

   function automatic logic [20:0] lim_of(input logic [31:0] c, input logic [1:0] n);
      case (n)
         2'h1: lim_of = stage_ms(c[sbw_pkg::F_TO1 +: 4]);
         2'h2: lim_of = stage_ms(c[sbw_pkg::F_TO2 +: 4]);
         default: lim_of = stage_ms(c[sbw_pkg::F_TO3 +: 4]);
      endcase
   endfunction

   // ==========================================================
   // time base and timers
   sbw_tick #(.CYC(TICK_CYC)) u_tick (.aclk(aclk), .aresetn(aresetn), .tick(tick));
   sbw_timer u_boot (.aclk(aclk), .aresetn(aresetn), .tick(tick), .t(boot_if.tmr));
   sbw_timer u_rt (.aclk(aclk), .aresetn(aresetn), .tick(tick), .t(rt_if.tmr));

   // ==========================================================
   // pin synchronisers: post, ui, os boot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         boot_d <= 1'b0;
      end else begin
         sync1 <= {os_boot, ui_wait, post_active};
         sync2 <= sync1;
         boot_d <= sync2[2];
      end
   end
   assign post_s = sync2[0];
   assign ui_s = sync2[1];
   assign arm_edge = sync2[2] & ~boot_d;
   assign mode = cfg[sbw_pkg::F_MODE +: 2];

   // ==========================================================
   // boot watchdog: reloaded outside self-test, paused on user wait
   assign boot_if.load = ~post_s;
   assign boot_if.limit = boot_ms(cfg[sbw_pkg::F_POST +: 3]);
   assign boot_if.run = post_s && cfg[sbw_pkg::F_POST +: 3] != 3'h0
                        && !(cfg[sbw_pkg::F_PAUSE] && ui_s);

   // ==========================================================
   // AXI4-Lite write channel: address and data in either order
   assign s_axi_awready = ~aw_got;
   assign s_axi_wready = ~w_got;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 5'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_got) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_got && w_got && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (dec(aw_addr) == 3'h0 || dec(aw_addr) == 3'h3
                            || dec(aw_addr) == 3'h4) ? 2'h2 : 2'h0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
         end
      end
   end

   // ==========================================================
   // software registers and trigger pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= sbw_pkg::CFG_RESET;
         int_mask <= sbw_pkg::MASK_RESET;
         kick <= 1'b0;
      end else begin
         kick <= 1'b0;
         if (aw_got && w_got && !s_axi_bvalid) begin
            if (dec(aw_addr) == 3'h1) cfg <= merge(cfg, w_data, w_strb) & 32'h0FFFFFFF;
            else if (dec(aw_addr) == 3'h2) kick <= 1'b1;
            else if (dec(aw_addr) == 3'h5) int_mask <= int_mask ^ ((int_mask ^ w_data[4:0]) & {5{w_strb[0]}});
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel; reading interrupt status clears it, new events win
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= (dec(s_axi_araddr) == 3'h0) ? 2'h2 : 2'h0;
         if (dec(s_axi_araddr) == 3'h1) s_axi_rdata <= cfg;
         else if (dec(s_axi_araddr) == 3'h3) s_axi_rdata <= {26'h0, boot_if.run, post_s, stage, state};
         else if (dec(s_axi_araddr) == 3'h4) s_axi_rdata <= {27'h0, int_stat};
         else if (dec(s_axi_araddr) == 3'h5) s_axi_rdata <= {27'h0, int_mask};
         else s_axi_rdata <= 32'h00000000;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_stat <= 5'h00;
         irq <= 1'b0;
      end else begin
         if (s_axi_arvalid && !s_axi_rvalid && dec(s_axi_araddr) == 3'h4) int_stat <= int_set;
         else int_stat <= int_stat | int_set;
         irq <= |((int_stat | int_set) & int_mask);
      end
   end

   // events: boot expiry, expiry of stages 1..3, arming
   always_comb begin
      int_set = 5'h00;
      int_set[sbw_pkg::I_BOOT] = boot_if.expired;
      if (fire) int_set[stage] = 1'b1;
      int_set[sbw_pkg::I_ARM] = arm_edge && state == sbw_pkg::RT_IDLE && mode != sbw_pkg::MODE_OFF;
   end

   // ==========================================================
   // runtime sequencer
   assign fire = rt_if.expired && state == sbw_pkg::RT_STAGE;
   assign fire_act = ev_of(cfg, stage);
   assign ev_next = ev_of(cfg, stage + 2'h1);
   assign last = stage == 2'h3 || ev_next == sbw_pkg::ACT_NONE;
   assign rt_if.load = rt_load;
   assign rt_if.limit = rt_limit;
   assign rt_if.run = (state == sbw_pkg::RT_DELAY || state == sbw_pkg::RT_STAGE) && !rt_load;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= sbw_pkg::RT_IDLE;
         stage <= 2'h0;
         rt_load <= 1'b0;
         rt_limit <= 21'h000000;
      end else begin
         rt_load <= 1'b0;
         case (state)
            sbw_pkg::RT_IDLE: begin
               if (arm_edge && mode != sbw_pkg::MODE_OFF) begin
                  rt_load <= 1'b1;
                  if (cfg[sbw_pkg::F_DELAY +: 3] != 3'h0) begin
                     state <= sbw_pkg::RT_DELAY;
                     rt_limit <= delay_ms(cfg[sbw_pkg::F_DELAY +: 3]);
                  end else begin
                     state <= sbw_pkg::RT_STAGE;
                     stage <= 2'h1;
                     rt_limit <= lim_of(cfg, 2'h1);
                  end
               end
            end
            sbw_pkg::RT_DELAY, sbw_pkg::RT_STAGE: begin
               if (mode == sbw_pkg::MODE_OFF) begin
                  state <= sbw_pkg::RT_IDLE;
                  stage <= 2'h0;
               end else if (kick && mode == sbw_pkg::MODE_ONCE) begin
                  state <= sbw_pkg::RT_DONE;
               end else if (kick || (rt_if.expired && state == sbw_pkg::RT_DELAY)) begin
                  state <= sbw_pkg::RT_STAGE;
                  stage <= 2'h1;
                  rt_load <= 1'b1;
                  rt_limit <= lim_of(cfg, 2'h1);
               end else if (fire && !last) begin
                  stage <= stage + 2'h1;
                  rt_load <= 1'b1;
                  rt_limit <= lim_of(cfg, stage + 2'h1);
               end else if (fire && mode == sbw_pkg::MODE_REPEAT) begin
                  rt_load <= 1'b1;
                  rt_limit <= lim_of(cfg, stage);
               end else if (fire) begin
                  state <= sbw_pkg::RT_DONE;
               end
            end
            default: begin
               state <= sbw_pkg::RT_DONE;
            end
         endcase
      end
   end

   // ==========================================================
   // action outputs: only platform event, reset and power button
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_reset <= 1'b0;
         pwrbtn_evt <= 1'b0;
         pm_overtemp <= 1'b0;
         pm_fatal <= 1'b0;
      end else begin
         sys_reset <= boot_if.expired || (fire && fire_act == sbw_pkg::ACT_RESET);
         pwrbtn_evt <= fire && fire_act == sbw_pkg::ACT_PWR;
         pm_overtemp <= fire && fire_act == sbw_pkg::ACT_PM && !cfg[sbw_pkg::F_RESTART];
         pm_fatal <= fire && fire_act == sbw_pkg::ACT_PM && cfg[sbw_pkg::F_RESTART];
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_boot_reset: assert property (boot_if.expired |=> sys_reset) else $error("boot expiry gave no reset");
   a_boot_post_only: assert property (!post_s |-> !boot_if.run ##1 !boot_if.expired) else $error("boot ran after post");
   a_boot_pause: assert property (cfg[3] && ui_s |-> !boot_if.run) else $error("boot ran while paused");
   a_arm_start: assert property (arm_edge && state == sbw_pkg::RT_IDLE && mode != 2'h0
      |=> state != sbw_pkg::RT_IDLE && rt_load) else $error("runtime not armed");
   a_once_kick: assert property (kick && mode == 2'h1 && (state == sbw_pkg::RT_DELAY || state == sbw_pkg::RT_STAGE)
      |=> state == sbw_pkg::RT_DONE [*2]) else $error("one-time not disabled");
   a_single_end: assert property (fire && last && !kick && mode == 2'h2
      |=> state == sbw_pkg::RT_DONE) else $error("single mode kept running");
   a_repeat_last: assert property (fire && last && !kick && mode == 2'h3
      |=> state == sbw_pkg::RT_STAGE && stage == $past(stage) && rt_load) else $error("repeat lost");
   a_delay_first: assert property (arm_edge && state == sbw_pkg::RT_IDLE && mode != 2'h0 && cfg[8:6] != 3'h0
      |=> state == sbw_pkg::RT_DELAY) else $error("delay skipped");
   a_stage_act: assert property (fire && fire_act == sbw_pkg::ACT_RESET |=> sys_reset ##1 !sys_reset || boot_if.expired)
      else $error("stage reset missing");
   a_stage_limit: assert property (rt_load && state == sbw_pkg::RT_STAGE |-> rt_limit == lim_of(cfg, stage) || $changed(cfg))
      else $error("stage limit wrong");
   a_pm_map: assert property (fire && fire_act == sbw_pkg::ACT_PM |=> pm_overtemp != pm_fatal)
      else $error("platform event not mapped");
   a_one_action: assert property ($onehot0({pwrbtn_evt, pm_overtemp, pm_fatal})) else $error("two actions");
   a_kick_restart: assert property (kick && mode[1] && state == sbw_pkg::RT_STAGE
      |=> stage == 2'h1 && rt_load) else $error("trigger did not restart");
   a_stage_order: assert property (fire && !last && !kick && mode != 2'h0
      |=> stage == $past(stage) + 2'h1) else $error("stage skipped");

   c_boot_expire: cover property (boot_if.expired ##1 sys_reset);
   c_stage_three: cover property (fire && stage == 2'h3);
   c_repeat: cover property (fire && mode == 2'h3 ##[1:1000] fire);
   c_once_kick: cover property (kick && mode == 2'h1);
endmodule

// >>> sbw_host.sv
// host-side model: self-test, boot menu and os boot pins
// assumes the bench calls its tasks; pins move just after rising edges
module sbw_host (
   // clock
   input wire logic aclk,
   // platform pins
   output logic post_active,
   output logic ui_wait,
   output logic os_boot
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // pins idle low until the bench moves them
   initial begin
      post_active = 1'b0;
      ui_wait = 1'b0;
      os_boot = 1'b0;
   end
   // self-test and menu levels
   task automatic pins(input logic p, input logic u);
      @(posedge aclk);
      post_active <= p;
      ui_wait <= u;
   endtask
   // os boot edge, held past the synchroniser
   task automatic boot();
      @(posedge aclk);
      os_boot <= 1'b1;
      repeat (4) @(posedge aclk);
      os_boot <= 1'b0;
   endtask
endmodule

// >>> test_staged_boot_runtime_watchdog.sv
// bench: register bus master, action timing model and verdict
// assumes sbw_wdt and sbw_host; short tick so the run stays brief
module test_staged_boot_runtime_watchdog;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 2;
   localparam int ST = 1000 * TK; // one second in cycles
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic post_active, ui_wait, os_boot;
   wire [3:0] act; // fatal, overtemp, power button, reset
   int n_errors = 0, compares = 0;
   logic [31:0] seed = 32'h00002476;
   logic [3:0] exp_q[$];
   int t_q[$];
   always #50 aclk = ~aclk;
   sbw_wdt #(.TICK_CYC(TK)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .post_active,
      .ui_wait, .os_boot, .sys_reset(act[0]), .pwrbtn_evt(act[1]), .pm_overtemp(act[2]), .pm_fatal(act[3]), .irq);
   sbw_host u_host (.aclk, .post_active, .ui_wait, .os_boot);
   // ==========
   // checks and verdict
   task automatic close_out();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic lim(input int n, input int b);
      if (n >= b) begin
         chk(32'h0, 32'h1, "wait bound");
         close_out();
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // ==========
   // register bus master: valids released as taken, answer sampled before its edge
   task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) break;
      end
      s_axi_bready <= 1'b0;
      lim(n, 50);
      chk(r, er, "bresp");
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      logic ta, tb;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tb = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tb) break;
      end
      s_axi_rready <= 1'b0;
      lim(n, 50);
      chk(r, er, "rresp");
      chk(d, e, "rdata");
   endtask
   // ==========
   // action model: which pulse and after how many cycles
   function automatic logic [3:0] code(input int e, input int rs);
      return (e == 2) ? 4'h1 : (e == 3) ? 4'h2 : (rs != 0) ? 4'h8 : 4'h4;
   endfunction
   function automatic logic [31:0] cfg(input int m, dl, e1, e2, e3, t2, rs);
      return 32'h9 | m << sbw_pkg::F_MODE | dl << sbw_pkg::F_DELAY | e1 << sbw_pkg::F_EV1 | e2 << sbw_pkg::F_EV2
         | e3 << sbw_pkg::F_EV3 | t2 << sbw_pkg::F_TO2 | rs << sbw_pkg::F_RESTART;
   endfunction
   task automatic wait_act(input logic [3:0] e, input int c);
      int n;
      for (n = 0; n < c + 20; n++) begin
         @(negedge aclk);
         if (act !== 4'h0) break;
      end
      chk(act, e, "action kind");
      chk(n > c - 20, 1'b1, "action early");
      lim(n, c + 20);
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge aclk);
         if (act !== 4'h0) chk(act, 4'h0, "stray action");
      end
      compares++;
   endtask
   task automatic run(input int m, dl, e1, e2, e3, t2, rs, kick);
      int ev[3];
      int tt[3];
      int i;
      ev = '{e1, e2, e3};
      tt = '{ST, ST * (t2 + 1), ST};
      exp_q.delete();
      t_q.delete();
      for (i = 0; i < 3 && ev[i] != 0; i++) begin
         exp_q.push_back(code(ev[i], rs));
         t_q.push_back(tt[i]);
      end
      repeat ((m == 3) ? 2 : 0) begin
         exp_q.push_back(exp_q[$]);
         t_q.push_back(t_q[$]);
      end
      if (m == 1 && kick != 0) exp_q.delete();
      // the done state only leaves on reset, so every run starts from one
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wr(sbw_pkg::OFS_CFG, cfg(0, dl, e1, e2, e3, t2, rs), 2'b00);
      wr(sbw_pkg::OFS_CFG, cfg(m, dl, e1, e2, e3, t2, rs), 2'b00);
      u_host.boot();
      if (kick != 0) begin
         repeat (ST / 2) @(posedge aclk);
         rd(sbw_pkg::OFS_STATUS, (dl != 0) ? 32'h00000001 : 32'h00000006, 2'b00);
         wr(sbw_pkg::OFS_TRIG, 32'h0, 2'b00);
      end
      while (exp_q.size() > 0) wait_act(exp_q.pop_front(), t_q.pop_front());
      if (m != 3) quiet(ST * 2);
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(sbw_pkg::OFS_CFG, sbw_pkg::CFG_RESET, 2'b00);
      rd(sbw_pkg::OFS_INT_MASK, 32'h0, 2'b00);
      rd(5'h14, 32'h0, 2'b10);
      wr(sbw_pkg::OFS_STATUS, 32'h3F, 2'b10);
      repeat (3) begin
         seed = xs(seed);
         wr(sbw_pkg::OFS_INT_MASK, seed, 2'b00);
         rd(sbw_pkg::OFS_INT_MASK, {27'h0, seed[4:0]}, 2'b00);
      end
      wr(sbw_pkg::OFS_INT_MASK, 32'h1F, 2'b00);
      wr(sbw_pkg::OFS_CFG, 32'h9, 2'b00);
      u_host.pins(1'b1, 1'b1);
      quiet(300);
      rd(sbw_pkg::OFS_STATUS, 32'h00000010, 2'b00);
      u_host.pins(1'b1, 1'b0);
      wait_act(4'h1, 30000 * TK);
      rd(sbw_pkg::OFS_STATUS, 32'h00000030, 2'b00);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b1, "irq raised");
      rd(sbw_pkg::OFS_INT_STAT, 32'h1, 2'b00);
      rd(sbw_pkg::OFS_INT_STAT, 32'h0, 2'b00);
      chk(irq, 1'b0, "irq cleared");
      u_host.pins(1'b0, 1'b0);
      wr(sbw_pkg::OFS_INT_MASK, 32'h0, 2'b00);
      rd(sbw_pkg::OFS_STATUS, 32'h00000000, 2'b00);
      run(2, 0, 1, 3, 2, 1, 0, 0);
      run(3, 0, 2, 1, 0, 0, 1, 0);
      run(2, 1, 3, 0, 0, 0, 0, 1);
      run(1, 0, 2, 0, 0, 0, 0, 1);
      chk(irq, 1'b0, "irq masked");
      wr(sbw_pkg::OFS_INT_MASK, 32'h1F, 2'b00);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b1, "irq unmasked");
      close_out();
   end
endmodule
